// >>> hdl/filt_consts.svh
// Constants for the codec decimation, interpolation and high pass filters
// Functional notes
// R1 - Decimator: flat passband, deep stopband above Nyquist
// R2 - Interpolator: flat passband, deep image rejection
// R3 - Selectable DC-removing high pass on converted input
// R4 - High pass: y = x - x1 + 0.9995*y1
// R5 - Deselected: pass through, clear filter history
`ifndef FILT_CONSTS_SVH
`define FILT_CONSTS_SVH
// ==================================================================
// Sample format
`define SMP_W 24
`define SMP_MAX 40'sh00007fffff
`define SMP_MIN 40'shffff800000
// ==================================================================
// Decimating half-band taps, sum scaled down by 2^DEC_SHIFT
`define DEC_DLY 6
`define DEC_CE 32'sh1
`define DEC_CM 32'sh9
`define DEC_CC 32'sh10
`define DEC_SHIFT 5
// ==================================================================
// Interpolating polyphase taps, sum scaled down by 2^INT_SHIFT
`define INT_DLY 4
`define INT_CE 32'sh1
`define INT_CM 32'sh9
`define INT_SHIFT 4
// ==================================================================
// High pass: feedback 0.9995 as a 16-bit fraction, state keeps 8 fraction bits
`define HPF_COEF 52'sh0ffdf
`define HPF_COEF_SHIFT 16
`define HPF_FRAC 8
`define HPF_ST_W 34
// ==================================================================
// Output buffer
`define FIFO_DEPTH 8
`endif

// >>> hdl/filt_pkg.sv
// Types shared by the filter blocks
package filt_pkg;
  `include "filt_consts.svh"
  typedef logic signed [`SMP_W-1:0] smp_t;
  typedef struct packed {
    smp_t [1:0] ch;
  } pair_t;
  typedef enum {D_TAKE, D_EVEN, D_ODD} dac_st_t;
  function automatic smp_t sat24(input logic signed [39:0] v);
    if (v > `SMP_MAX) begin
      return smp_t'(`SMP_MAX);
    end else if (v < `SMP_MIN) begin
      return smp_t'(`SMP_MIN);
    end
    return smp_t'(v);
  endfunction
endpackage

// >>> hdl/sample_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module sample_fifo #(
  parameter int W = 48,
  parameter int D = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_r];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> hdl/codec_filters.sv
// Stereo decimation with DC high pass, and stereo 2x interpolation
`timescale 1ns/1ns
`include "filt_consts.svh"
module codec_filters
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic hpf_sel,
  input wire logic adc_in_valid,
  output logic adc_in_ready,
  input wire filt_pkg::pair_t adc_in_data,
  output logic adc_out_valid,
  input wire logic adc_out_ready,
  output filt_pkg::pair_t adc_out_data,
  input wire logic dac_in_valid,
  output logic dac_in_ready,
  input wire filt_pkg::pair_t dac_in_data,
  output logic dac_out_valid,
  input wire logic dac_out_ready,
  output filt_pkg::pair_t dac_out_data
);
  // ==================================================================
  // High pass select pin, synchronised
  logic hpf_s1_r;
  logic hpf_on_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      hpf_s1_r <= 1'b0;
      hpf_on_r <= 1'b0;
    end else begin
      hpf_s1_r <= hpf_sel;
      hpf_on_r <= hpf_s1_r;
    end
  end

  // ==================================================================
  // Decimation by two
  filt_pkg::pair_t adc_dly_r [0:`DEC_DLY-1];
  filt_pkg::pair_t dec_raw;
  filt_pkg::pair_t dec_sel;
  filt_pkg::pair_t dec_data_r;
  logic adc_phase_r;
  logic dec_vld_r;
  logic fifo_in_ready;
  wire adc_fire = adc_in_valid && adc_in_ready;
  wire dec_go = adc_fire && adc_phase_r;
  // A held result only blocks the input while the buffer refuses it
  assign adc_in_ready = !dec_vld_r || fifo_in_ready;

  always_ff @(posedge mclk) begin
    if (srst) begin
      adc_dly_r[0] <= '0;
    end else if (adc_fire) begin
      adc_dly_r[0] <= adc_in_data;
    end
  end

  genvar k;
  generate
    for (k = 1; k < `DEC_DLY; k++) begin : g_dly
      always_ff @(posedge mclk) begin
        if (srst) begin
          adc_dly_r[k] <= '0;
        end else if (adc_fire) begin
          adc_dly_r[k] <= adc_dly_r[k-1];
        end
      end
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic signed [31:0] dsum;
      logic signed [`HPF_ST_W-1:0] x1_r;
      logic signed [`HPF_ST_W-1:0] y1_r;
      logic signed [`HPF_ST_W-1:0] x_cur;
      logic signed [51:0] fb;
      logic signed [`HPF_ST_W-1:0] y_nxt;
      // Symmetric half-band: the taps two places either side of the centre are zero
      assign dsum = (`DEC_CM * 32'(adc_dly_r[1].ch[c]) + `DEC_CM * 32'(adc_dly_r[3].ch[c])
        + `DEC_CC * 32'(adc_dly_r[2].ch[c]) - `DEC_CE * 32'(adc_in_data.ch[c])
        - `DEC_CE * 32'(adc_dly_r[5].ch[c])) >>> `DEC_SHIFT; // [R1]
      assign dec_raw.ch[c] = filt_pkg::sat24(40'(dsum));
      // State carries fraction bits so the slow pole does not stall on rounding
      assign x_cur = `HPF_ST_W'(dec_raw.ch[c]) <<< `HPF_FRAC;
      assign fb = (52'(y1_r) * `HPF_COEF) >>> `HPF_COEF_SHIFT;
      assign y_nxt = x_cur - x1_r + `HPF_ST_W'(fb); // [R4]
      assign dec_sel.ch[c] = hpf_on_r
        ? filt_pkg::sat24(40'(y_nxt >>> `HPF_FRAC)) : dec_raw.ch[c]; // [R3] [R5]

      always_ff @(posedge mclk) begin
        if (srst || (dec_go && !hpf_on_r)) begin
          x1_r <= '0; // [R5]
          y1_r <= '0;
        end else if (dec_go) begin
          x1_r <= x_cur; // [R4]
          y1_r <= y_nxt;
        end
      end

      a_hpf_clear: assert property (@(posedge mclk) disable iff (srst)
        dec_go && !hpf_on_r |=> x1_r == '0 && y1_r == '0) // [R5]
        else $error("high pass history not cleared while bypassed");
      a_hpf_history: assert property (@(posedge mclk) disable iff (srst)
        dec_go && hpf_on_r |=> x1_r == ($past(`HPF_ST_W'(dec_raw.ch[c])) <<< `HPF_FRAC)) // [R4]
        else $error("high pass did not keep previous input");
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) begin
      adc_phase_r <= 1'b0;
      dec_vld_r <= 1'b0;
      dec_data_r <= '0;
    end else begin
      if (adc_fire) begin
        adc_phase_r <= !adc_phase_r; // [R1]
      end
      if (dec_go) begin
        dec_vld_r <= 1'b1;
        dec_data_r <= dec_sel;
      end else if (fifo_in_ready) begin
        dec_vld_r <= 1'b0;
      end
    end
  end

  sample_fifo #(.W($bits(filt_pkg::pair_t)), .D(`FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(dec_vld_r),
    .in_ready(fifo_in_ready),
    .in_data(dec_data_r),
    .out_valid(adc_out_valid),
    .out_ready(adc_out_ready),
    .out_data(adc_out_data)
  );

  a_hpf_bypass: assert property (@(posedge mclk) disable iff (srst)
    dec_go && !hpf_on_r |=> dec_vld_r && dec_data_r == $past(dec_raw)) // [R5]
    else $error("bypassed sample altered");
  a_dec_rate: assert property (@(posedge mclk) disable iff (srst)
    adc_fire && !adc_phase_r |-> !dec_go ##1 adc_phase_r) // [R1]
    else $error("decimator produced on the wrong phase");

  // ==================================================================
  // Interpolation by two: even output from four taps, odd output is a delayed input
  filt_pkg::pair_t int_dly_r [0:`INT_DLY-1];
  filt_pkg::pair_t int_even;
  filt_pkg::dac_st_t dac_st_r;
  filt_pkg::pair_t dac_data_r;
  wire dac_fire = dac_in_valid && dac_in_ready;
  wire dac_take = dac_out_valid && dac_out_ready;
  assign dac_in_ready = (dac_st_r == filt_pkg::D_TAKE);
  assign dac_out_valid = (dac_st_r != filt_pkg::D_TAKE);
  assign dac_out_data = dac_data_r;

  generate
    for (c = 0; c < 2; c++) begin : g_int
      logic signed [31:0] isum;
      assign isum = (`INT_CM * 32'(int_dly_r[0].ch[c]) + `INT_CM * 32'(int_dly_r[1].ch[c])
        - `INT_CE * 32'(dac_in_data.ch[c]) - `INT_CE * 32'(int_dly_r[2].ch[c]))
        >>> `INT_SHIFT; // [R2]
      assign int_even.ch[c] = filt_pkg::sat24(40'(isum));
    end
    for (k = 1; k < `INT_DLY; k++) begin : g_idly
      always_ff @(posedge mclk) begin
        if (srst) begin
          int_dly_r[k] <= '0;
        end else if (dac_fire) begin
          int_dly_r[k] <= int_dly_r[k-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) begin
      int_dly_r[0] <= '0;
      dac_st_r <= filt_pkg::D_TAKE;
      dac_data_r <= '0;
    end else begin
      case (dac_st_r)
        filt_pkg::D_TAKE: begin
          if (dac_fire) begin
            int_dly_r[0] <= dac_in_data;
            dac_data_r <= int_even; // [R2]
            dac_st_r <= filt_pkg::D_EVEN;
          end
        end
        filt_pkg::D_EVEN: begin
          if (dac_take) begin
            dac_data_r <= int_dly_r[1]; // [R2]
            dac_st_r <= filt_pkg::D_ODD;
          end
        end
        filt_pkg::D_ODD: begin
          if (dac_take) begin
            dac_st_r <= filt_pkg::D_TAKE;
          end
        end
        default: begin
          dac_st_r <= filt_pkg::D_TAKE;
        end
      endcase
    end
  end

  sequence s_even_out;
    dac_take && dac_st_r == filt_pkg::D_EVEN;
  endsequence
  sequence s_odd_ready;
    dac_out_valid && dac_st_r == filt_pkg::D_ODD && dac_data_r == $past(int_dly_r[1]);
  endsequence
  a_dac_pair: assert property (@(posedge mclk) disable iff (srst)
    s_even_out |=> s_odd_ready) // [R2]
    else $error("interpolator odd phase missing or wrong");
  a_dac_even: assert property (@(posedge mclk) disable iff (srst)
    dac_fire |=> dac_st_r == filt_pkg::D_EVEN && dac_data_r == $past(int_even)) // [R2]
    else $error("interpolator even phase wrong");
endmodule

// >>> sim/audio_side_model.sv
// Far-side consumer model for converted and playback samples
`timescale 1ns/1ns
module audio_side_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [1:0] stall,
  output logic adc_out_ready,
  output logic dac_out_ready
);
  logic [1:0] cnt_r;
  always_ff @(posedge mclk) begin
    cnt_r <= srst ? 2'h0 : cnt_r + 2'h1;
  end
  // Mode 1 takes one converted word in four and three playback words in four, mode 2 refuses all so the buffer fills
  assign adc_out_ready = (stall == 2'h0) || (stall == 2'h1 && cnt_r == 2'h0);
  assign dac_out_ready = (stall == 2'h0) || (stall == 2'h1 && cnt_r != 2'h3);
endmodule

// >>> sim/codec_decimation_interpolation_filters_test.sv
// Self-checking bench for the decimation, interpolation and high pass filters
`timescale 1ns/1ns
module codec_decimation_interpolation_filters_test;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic hpf_sel = 1'b0;
  logic adc_in_valid = 1'b0;
  logic dac_in_valid = 1'b0;
  logic [1:0] stall = 2'h0;
  logic adc_in_ready, adc_out_valid, adc_out_ready, dac_in_ready, dac_out_valid, dac_out_ready;
  filt_pkg::pair_t adc_in_data = '0;
  filt_pkg::pair_t dac_in_data = '0;
  filt_pkg::pair_t adc_out_data, dac_out_data, ev, od;
  filt_pkg::pair_t exp_adc[$];
  filt_pkg::pair_t exp_dac[$];
  longint ah[2][7], dh[2][4], y1[2], x1[2];
  int seed = 91;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  bit ph, corner, adc_run, dac_run;

  codec_filters dut (.mclk(mclk), .srst(srst), .hpf_sel(hpf_sel),
    .adc_in_valid(adc_in_valid), .adc_in_ready(adc_in_ready), .adc_in_data(adc_in_data),
    .adc_out_valid(adc_out_valid), .adc_out_ready(adc_out_ready), .adc_out_data(adc_out_data),
    .dac_in_valid(dac_in_valid), .dac_in_ready(dac_in_ready), .dac_in_data(dac_in_data),
    .dac_out_valid(dac_out_valid), .dac_out_ready(dac_out_ready), .dac_out_data(dac_out_data));
  audio_side_model far (.mclk(mclk), .srst(srst), .stall(stall),
    .adc_out_ready(adc_out_ready), .dac_out_ready(dac_out_ready));

  // ==================================================================
  // Reference arithmetic
  function automatic longint sat(input longint v);
    return v > 64'sh7fffff ? 64'sh7fffff : (v < -64'sh800000 ? -64'sh800000 : v);
  endfunction
  // Corner mode gives full scale of random sign; some sign runs push the sums past full scale
  function automatic filt_pkg::pair_t next_in();
    filt_pkg::pair_t p;
    for (int c = 0; c < 2; c++) begin
      if (corner) begin
        p.ch[c] = ($random(seed) & 1) ? 24'sh7fffff : 24'sh800000;
      end else begin
        p.ch[c] = filt_pkg::smp_t'($random(seed));
      end
    end
    return p;
  endfunction
  function automatic filt_pkg::pair_t dec_pair();
    filt_pkg::pair_t p;
    longint d, y;
    for (int c = 0; c < 2; c++) begin
      d = sat((64'sh9 * (ah[c][2] + ah[c][4]) + 64'sh10 * ah[c][3] - ah[c][0] - ah[c][6]) >>> 5);
      y = d * 64'sh100 - x1[c] + ((y1[c] * 64'shffdf) >>> 16);
      p.ch[c] = filt_pkg::smp_t'(hpf_sel ? sat(y >>> 8) : d);
      x1[c] = hpf_sel ? d * 64'sh100 : 64'sh0;
      y1[c] = hpf_sel ? y : 64'sh0;
    end
    return p;
  endfunction
  function automatic longint even_ref(input int c);
    return sat((64'sh9 * (dh[c][1] + dh[c][2]) - dh[c][0] - dh[c][3]) >>> 4);
  endfunction

  // ==================================================================
  // Drivers, monitors and checks
  always @(posedge mclk) begin
    if (adc_in_valid && adc_in_ready) begin
      for (int c = 0; c < 2; c++) begin
        for (int k = 6; k > 0; k--) ah[c][k] = ah[c][k-1];
        ah[c][0] = adc_in_data.ch[c];
      end
      if (ph) exp_adc.push_back(dec_pair());
      ph = !ph;
      adc_in_data <= next_in();
    end
    adc_in_valid <= adc_run || (adc_in_valid && !adc_in_ready);
  end
  always @(posedge mclk) begin
    if (dac_in_valid && dac_in_ready) begin
      for (int c = 0; c < 2; c++) begin
        for (int k = 3; k > 0; k--) dh[c][k] = dh[c][k-1];
        dh[c][0] = dac_in_data.ch[c];
        ev.ch[c] = filt_pkg::smp_t'(even_ref(c));
        od.ch[c] = filt_pkg::smp_t'(dh[c][1]);
      end
      exp_dac.push_back(ev);
      exp_dac.push_back(od);
      dac_in_data <= next_in();
    end
    dac_in_valid <= dac_run || (dac_in_valid && !dac_in_ready);
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (adc_out_valid === 1'b1 && adc_out_ready) begin
      chk("adc_out_data", exp_adc.pop_front(), adc_out_data);
    end
    if (dac_out_valid === 1'b1 && dac_out_ready) begin
      chk("dac_out_data", exp_dac.pop_front(), dac_out_data);
    end
    if (!srst) begin
      chk("dac_in_ready", 48'(!dac_out_valid), 48'(dac_in_ready));
    end
    if (cyc == 32'h4e20) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic drain();
    while (exp_adc.size() + exp_dac.size() > 0 || adc_in_valid || dac_in_valid) @(negedge mclk);
  endtask
  task automatic run(input bit hs, input bit cr, input logic [1:0] st, input int n);
    @(posedge mclk);
    hpf_sel <= hs;
    corner <= cr;
    stall <= st;
    repeat (4) @(posedge mclk);
    adc_run <= 1'b1;
    dac_run <= 1'b1;
    repeat (n) @(posedge mclk);
    adc_run <= 1'b0;
    dac_run <= 1'b0;
    drain();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    forever #50 mclk = !mclk;
  end
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    run(1'b0, 1'b0, 2'h0, 200);
    run(1'b0, 1'b1, 2'h1, 60);
    run(1'b1, 1'b0, 2'h1, 300);
    run(1'b1, 1'b1, 2'h0, 60);
    run(1'b0, 1'b0, 2'h0, 100);
    run(1'b1, 1'b0, 2'h0, 100);
    // Consumer refuses all: eight buffered results plus one held, then input stalls
    @(posedge mclk);
    stall <= 2'h2;
    adc_run <= 1'b1;
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    chk("adc_in_ready", 48'h0, 48'(adc_in_ready));
    chk("results_pending", 48'h9, 48'(exp_adc.size()));
    @(posedge mclk);
    adc_run <= 1'b0;
    stall <= 2'h1;
    drain();
    @(negedge mclk);
    chk("adc_out_valid", 48'h0, 48'(adc_out_valid));
    results();
  end
endmodule
